// *** src/shp_pkg.sv ***
// constants and types for the serial host port
package shp_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int NREG = 128;
   localparam int FRAME_W = 8;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [ADDR_W-1:0] REG_RATE_A = 7'h22;
   localparam int RATE_A_BIT = 2;
   localparam logic [ADDR_W-1:0] REG_RATE_B = 7'h26;
   localparam int RATE_B_LO = 5;
   localparam int RATE_B_HI = 6;
   localparam logic [DATA_W-1:0] REG_RST_VAL = 8'h00;
   localparam int SYNC_W = 6;
   localparam int PIN_SCLK = 5;
   localparam int PIN_SIN = 4;
   localparam int PIN_CS = 3;
   localparam int PIN_SEL = 2;
   localparam int PIN_MRES = 1;
   localparam int PIN_STRAP = 0;
   localparam logic [SYNC_W-1:0] SYNC_RST = 6'h08;
   typedef enum logic [3:0] {
      SHP_IDLE = 4'h1,
      SHP_CMD = 4'h2,
      SHP_WR = 4'h4,
      SHP_RD = 4'h8
   } shp_state_e;
endpackage

// *** src/shp_serial_port.sv ***
// serial host port with master reset and rate-family strap
// Behaviour
// - transfers happen only while select is low; high select ignores the port.
// - edge select at one makes the serial clock falling edge active.
// - with edge select zero, serial input is captured on rising edges.
// - host shifts command, address and write data; device writes the register.
// - read data is shifted out serially, most significant bit first.
// - low master reset returns all state and registers to defaults.
// - at power-up or master reset, rate bits load from the strap level.
// - strap low gives the SDH family, strap high the SONET family.
// - software writes may later override the rate bits freely.
`timescale 1ns/10ps
`default_nettype none
module shp_serial_port (
   input wire logic clock,
   input wire logic rst,
   input wire logic serial_clk,
   input wire logic host_select_n,
   input wire logic serial_in,
   input wire logic serial_edge_select,
   input wire logic master_reset_n,
   input wire logic rate_family_strap,
   output logic serial_out,
   output logic serial_out_en,
   output logic [2:0] rate_family_bits
);
   import shp_pkg::*;

   logic [SYNC_W-1:0] pin_s;
   logic sclk_s, sin_s, cs_s, sel_s, mres_s, strap_s;
   shp_state_e state_reg, state_next;
   logic [2:0] cnt_reg, cnt_next;
   logic [DATA_W-2:0] shift_reg, shift_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [DATA_W-1:0] oshift_reg, oshift_next;
   logic sclk_prev_reg;
   logic sout_reg, sout_next;
   logic sout_en_reg, sout_en_next;
   logic pending_reg, pending_next;
   logic [DATA_W-1:0] regs_reg [0:NREG-1];
   logic [DATA_W-1:0] regs_next [0:NREG-1];
   logic rise, fall, active, launch, wr_done;
   logic [FRAME_W-1:0] full;

   shp_sync #(.WIDTH(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
      .clock(clock),
      .rst(rst),
      .pin_in({serial_clk, serial_in, host_select_n, serial_edge_select,
               master_reset_n, rate_family_strap}),
      .pin_sync(pin_s)
   );

   assign sclk_s = pin_s[PIN_SCLK];
   assign sin_s = pin_s[PIN_SIN];
   assign cs_s = pin_s[PIN_CS];
   assign sel_s = pin_s[PIN_SEL];
   assign mres_s = pin_s[PIN_MRES];
   assign strap_s = pin_s[PIN_STRAP];

   // picks the falling or rising edge by the select level
   function automatic logic edge_pick(input logic r, input logic f, input logic use_fall);
      return use_fall ? f : r;
   endfunction

   assign rise = sclk_s & ~sclk_prev_reg;
   assign fall = ~sclk_s & sclk_prev_reg;
   assign active = edge_pick(rise, fall, sel_s);
   assign launch = edge_pick(rise, fall, ~sel_s);
   assign full = {shift_reg, sin_s};

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      addr_next = addr_reg;
      oshift_next = oshift_reg;
      sout_next = sout_reg;
      pending_next = pending_reg;
      wr_done = 1'b0;
      for (int i = 0; i < NREG; i++) begin
         regs_next[i] = regs_reg[i];
      end
      if (!mres_s) begin
         // master reset clears everything to defaults
         state_next = SHP_IDLE;
         cnt_next = 3'h0;
         shift_next = '0;
         addr_next = '0;
         oshift_next = '0;
         sout_next = 1'b0;
         for (int i = 0; i < NREG; i++) begin
            regs_next[i] = REG_RST_VAL;
         end
         pending_next = 1'b1;
      end else begin
         pending_next = 1'b0;
         case (state_reg)
            SHP_IDLE: begin
               if (!cs_s) begin
                  state_next = SHP_CMD;
                  cnt_next = 3'h0;
               end
            end
            SHP_CMD: begin
               if (active) begin
                  shift_next = full[DATA_W-2:0];
                  cnt_next = cnt_reg + 3'h1;
                  if (cnt_reg == LAST_BIT) begin
                     // first bit is read flag, then address
                     addr_next = full[ADDR_W-1:0];
                     if (full[FRAME_W-1]) begin
                        state_next = SHP_RD;
                        oshift_next = regs_reg[full[ADDR_W-1:0]];
                     end else begin
                        state_next = SHP_WR;
                     end
                  end
               end
            end
            SHP_WR: begin
               if (active) begin
                  shift_next = full[DATA_W-2:0];
                  cnt_next = cnt_reg + 3'h1;
                  if (cnt_reg == LAST_BIT) begin
                     wr_done = 1'b1;
                     regs_next[addr_reg] = full;
                     state_next = SHP_CMD;
                  end
               end
            end
            SHP_RD: begin
               if (launch) begin
                  sout_next = oshift_reg[DATA_W-1];
                  oshift_next = {oshift_reg[DATA_W-2:0], 1'b0};
               end
               if (active) begin
                  cnt_next = cnt_reg + 3'h1;
                  if (cnt_reg == LAST_BIT) begin
                     state_next = SHP_CMD;
                  end
               end
            end
            default: begin
               state_next = SHP_IDLE;
            end
         endcase
         if (cs_s) begin
            state_next = SHP_IDLE;
            cnt_next = 3'h0;
         end
      end
      if (!mres_s || pending_reg) begin
         // strap level seeds the rate-family bits
         regs_next[REG_RATE_A][RATE_A_BIT] = strap_s;
         regs_next[REG_RATE_B][RATE_B_LO] = strap_s;
         regs_next[REG_RATE_B][RATE_B_HI] = strap_s;
      end
      sout_en_next = mres_s && !cs_s && (state_next == SHP_RD);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= SHP_IDLE;
         cnt_reg <= 3'h0;
         shift_reg <= '0;
         addr_reg <= '0;
         oshift_reg <= '0;
         sclk_prev_reg <= 1'b0;
         sout_reg <= 1'b0;
         sout_en_reg <= 1'b0;
         pending_reg <= 1'b1;
         for (int i = 0; i < NREG; i++) begin
            regs_reg[i] <= REG_RST_VAL;
         end
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         addr_reg <= addr_next;
         oshift_reg <= oshift_next;
         sclk_prev_reg <= sclk_s;
         sout_reg <= sout_next;
         sout_en_reg <= sout_en_next;
         pending_reg <= pending_next;
         for (int i = 0; i < NREG; i++) begin
            regs_reg[i] <= regs_next[i];
         end
      end
   end

   assign serial_out = sout_reg;
   assign serial_out_en = sout_en_reg;
   assign rate_family_bits = {regs_reg[REG_RATE_B][RATE_B_HI], regs_reg[REG_RATE_B][RATE_B_LO],
                              regs_reg[REG_RATE_A][RATE_A_BIT]};

   // checks
   idle_ignore_a: assert property (@(posedge clock) disable iff (rst)
      cs_s |=> state_reg == SHP_IDLE && cnt_reg == 3'h0)
      else $error("select high did not hold the port idle");
   fall_edge_a: assert property (@(posedge clock) disable iff (rst)
      sel_s && rise && mres_s && !cs_s && state_reg == SHP_CMD |=> $stable(cnt_reg))
      else $error("rising edge counted while falling edge selected");
   rise_capture_a: assert property (@(posedge clock) disable iff (rst)
      !sel_s && rise && mres_s && !cs_s && state_reg == SHP_WR && cnt_reg != LAST_BIT
      |=> shift_reg[0] == $past(sin_s))
      else $error("input bit not captured on rising edge");
   write_store_a: assert property (@(posedge clock) disable iff (rst)
      wr_done && !cs_s && addr_reg != REG_RATE_A && addr_reg != REG_RATE_B
      |=> regs_reg[$past(addr_reg)] == $past(full))
      else $error("write data not stored");
   read_out_a: assert property (@(posedge clock) disable iff (rst)
      mres_s && state_reg == SHP_RD && launch |=> serial_out == $past(oshift_reg[DATA_W-1]))
      else $error("read bit not launched");
   mreset_clear_a: assert property (@(posedge clock) disable iff (rst)
      !mres_s |=> state_reg == SHP_IDLE && regs_reg[0] == REG_RST_VAL && !serial_out_en)
      else $error("master reset did not clear state");
   strap_load_a: assert property (@(posedge clock) disable iff (rst)
      !mres_s ##1 !mres_s |=> rate_family_bits == {3{$past(strap_s)}})
      else $error("rate bits not loaded from strap");
   strap_family_a: assert property (@(posedge clock) disable iff (rst)
      !mres_s && !strap_s |=> rate_family_bits == 3'h0)
      else $error("low strap did not select SDH rates");
   sw_override_a: assert property (@(posedge clock) disable iff (rst)
      wr_done && !cs_s && !pending_reg && addr_reg == REG_RATE_B
      |=> regs_reg[REG_RATE_B] == $past(full))
      else $error("software could not override rate bits");
   out_float_a: assert property (@(posedge clock) disable iff (rst)
      cs_s |=> !serial_out_en)
      else $error("output driven with select high");
   write_seen_c: cover property (@(posedge clock) disable iff (rst) wr_done);
   read_seen_c: cover property (@(posedge clock) disable iff (rst)
      state_reg == SHP_RD && cnt_reg == LAST_BIT && active);
   fall_mode_c: cover property (@(posedge clock) disable iff (rst) sel_s && wr_done);
endmodule
`default_nettype wire

// *** src/shp_sync.sv ***
// two-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none
module shp_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_reg;
         logic sync_reg;
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               meta_reg <= RST_VAL[i];
               sync_reg <= RST_VAL[i];
            end else begin
               meta_reg <= pin_in[i];
               sync_reg <= meta_reg;
            end
         end
         assign pin_sync[i] = sync_reg;
      end
   endgenerate
endmodule
`default_nettype wire

// *** test/shp_host_model.sv ***
// host model that drives frames on the serial host port
`timescale 1ns/10ps
`default_nettype none
module shp_host_model (
   input wire logic clock,
   input wire logic edge_sel,
   input wire logic serial_out,
   input wire logic serial_out_en,
   output logic serial_clk,
   output logic host_select_n,
   output logic serial_in
);
   initial begin
      serial_clk = 1'h0;
      host_select_n = 1'h1;
      serial_in = 1'h0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock);
   endtask
   // one 16-bit frame; sel_n high sends it with select held off
   task automatic frame(input logic [15:0] word, input logic sel_n, output logic [7:0] rd);
      logic idle;
      idle = edge_sel;
      rd = 8'h00;
      serial_clk <= idle;
      wait_clk(12);
      host_select_n <= sel_n;
      for (int i = 15; i >= 0; i--) begin
         serial_in <= word[i];
         wait_clk(12);
         serial_clk <= ~idle;
         if (i < 8) begin
            // an undriven output line falls to its pull-down level
            rd[i] = serial_out_en ? serial_out : 1'h0;
         end
         wait_clk(13);
         serial_clk <= idle;
      end
      wait_clk(12);
      host_select_n <= 1'h1;
      // released data line falls to its pull-down level
      serial_in <= 1'h0;
      wait_clk(12);
   endtask
endmodule
`default_nettype wire

// *** test/shp_serial_port_test.sv ***
// testbench for the serial host port
`timescale 1ns/10ps
`default_nettype none
module shp_serial_port_test;
   import shp_pkg::*;
   logic clock, rst, serial_clk, host_select_n, serial_in, serial_edge_select;
   logic master_reset_n, rate_family_strap, serial_out, serial_out_en;
   logic [2:0] rate_family_bits;
   logic [7:0] rd;
   int n_fail = 0;
   int compares = 0;
   shp_serial_port shp_serial_port_inst (.clock(clock), .rst(rst), .serial_clk(serial_clk),
      .host_select_n(host_select_n), .serial_in(serial_in),
      .serial_edge_select(serial_edge_select), .master_reset_n(master_reset_n),
      .rate_family_strap(rate_family_strap), .serial_out(serial_out),
      .serial_out_en(serial_out_en), .rate_family_bits(rate_family_bits));
   shp_host_model shp_host_model_inst (.clock(clock), .edge_sel(serial_edge_select),
      .serial_out(serial_out), .serial_out_en(serial_out_en), .serial_clk(serial_clk),
      .host_select_n(host_select_n),
      .serial_in(serial_in));
   initial begin
      clock = 1'h0;
      forever #2.5 clock = ~clock;
   end
   task automatic complete_run;
      $display("mismatches %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] dummy;
      shp_host_model_inst.frame({1'h0, a, d}, 1'h0, dummy);
   endtask
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
      shp_host_model_inst.frame({1'h1, a, 8'h00}, 1'h0, rd);
      check("read data", exp, rd);
   endtask
   task automatic rate_chk(input logic [2:0] exp);
      check("rate bits", {5'h00, exp}, {5'h00, rate_family_bits});
   endtask
   initial begin
      rst = 1'h1;
      master_reset_n = 1'h1;
      rate_family_strap = 1'h1;
      serial_edge_select = 1'h0;
      repeat (20) @(posedge clock);
      rst <= 1'h0;
      repeat (10) @(posedge clock);
      rate_chk(3'h7);
      rd_chk(REG_RATE_A, 8'h04);
      wr(REG_RATE_A, 8'h00);
      rate_chk(3'h6);
      rd_chk(REG_RATE_B, 8'h60);
      wr(REG_RATE_B, 8'h40);
      rate_chk(3'h4);
      wr(7'h05, 8'ha5);
      rd_chk(7'h05, 8'ha5);
      check("output enable", 8'h00, {7'h00, serial_out_en});
      shp_host_model_inst.frame({1'h0, 7'h05, 8'h3c}, 1'h1, rd);
      rd_chk(7'h05, 8'ha5);
      serial_edge_select <= 1'h1;
      repeat (8) @(posedge clock);
      wr(7'h06, 8'h5a);
      rd_chk(7'h06, 8'h5a);
      wr(REG_RATE_A, 8'h04);
      rate_chk(3'h5);
      rate_family_strap <= 1'h0;
      master_reset_n <= 1'h0;
      repeat (10) @(posedge clock);
      rate_chk(3'h0);
      master_reset_n <= 1'h1;
      repeat (10) @(posedge clock);
      rate_chk(3'h0);
      rd_chk(7'h05, 8'h00);
      rd_chk(7'h06, 8'h00);
      complete_run();
   end
   initial begin
      #100000;
      n_fail++;
      complete_run();
   end
endmodule
`default_nettype wire
